// >>> rtl/byte_ram.sv
// byte-wide memory, one write port, one registered read port
`timescale 1ns/1ns
module byte_ram #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // contents carry no reset, like the nonvolatile cells of the array and register bank; the page buffer uses it too
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule

// >>> rtl/twi_slave_pkg.sv
// constants, state codes and carriers shared by the two-wire slave memory port
package twi_slave_pkg;

  // ***********************
  // timing
  // ***********************
  localparam int CLK_MHZ     = 50;
  localparam int NVW_TIME_US = 5000;
  localparam int NVW_CYCLES  = NVW_TIME_US * CLK_MHZ;

  // ***********************
  // addressing
  // ***********************
  localparam logic [6:0]  ARRAY_ID    = 7'h57;
  localparam logic [6:0]  CCR_ID      = 7'h6f;
  localparam int          ARRAY_AW    = 9;
  localparam int          CCR_AW      = 6;
  localparam int          PAGE_AW     = 6;
  localparam int          SECT_AW     = 3;
  localparam logic [15:0] ADDR_RST    = 16'h0000;
  localparam logic [15:0] STATUS_ADDR = 16'h003f;

  // ***********************
  // status register values
  // ***********************
  localparam logic [7:0] SR_CLEAR    = 8'h00;
  localparam logic [7:0] SR_SET_WEL  = 8'h02;
  localparam logic [7:0] SR_SET_REGISTER_WRITE_ENABLE_LATCH = 8'h06;

  // ***********************
  // bit slots within a byte frame
  // ***********************
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_AHI  = 3'b010,
    ST_ALO  = 3'b011,
    ST_WDAT = 3'b100,
    ST_RDAT = 3'b101
  } port_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } twi_in_s;

  typedef struct packed {
    logic        en;
    logic [15:0] base;
  } prot_cfg_s;

endpackage

// >>> rtl/twi_slave_port.sv
// serial slave port: start/stop detection, addressing, paged writes and reads
`timescale 1ns/1ns

// Operation
// [RULE1] master changes data only while clock low
// [RULE2] ignore everything until a start condition
// [RULE3] stop ends transaction, returns to standby
// [RULE4] release after eight bits, ack in ninth
// [RULE5] nack bad id, disabled writes, second status byte
// [RULE6] read: send byte, check ack, continue
// [RULE7] upper nibble selects array or register bank
// [RULE8] match seven bits; last bit read/write
// [RULE9] two word address bytes, else counter
// [RULE10] address counter clears to zero at reset
// [RULE11] random read reuses same slave byte
// [RULE12] master enables registers with 02h then 06h
// [RULE13] valid write stop starts busy cycle
// [RULE14] protected writes acked but discarded
// [RULE15] page write wraps within page or section
// [RULE16] partial byte stop aborts write entirely
// [RULE17] busy device withholds ack to polling
// [RULE18] master polls with array slave byte only
// [RULE19] counter points one past last read
// [RULE20] master ends read with nack and stop
// [RULE21] random read: dummy write, repeated start
// [RULE22] stop after address loads counter, standby
// [RULE23] register write completion clears register latch
// [RULE24] status zero clears both latches
// [RULE25] sequential reads wrap whole address space
// [RULE26] busy interval length is configurable
module twi_slave_port
  import twi_slave_pkg::*;
#(
  parameter int NVW_LEN     = twi_slave_pkg::NVW_CYCLES,
  parameter int ARRAY_DEPTH = 512,
  parameter int CCR_DEPTH   = 64
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire twi_slave_pkg::twi_in_s   bus_in,
  input  wire twi_slave_pkg::prot_cfg_s prot,
  output logic                         sda_o,
  output logic                         sda_oe,
  output logic                         busy
);

  // ***********************
  // pin synchronisers and edge detection
  // ***********************
  twi_in_s     meta_r;
  twi_in_s     sync_r;
  twi_in_s     prev_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_evt;
  logic        stop_evt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= bus_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign scl_rise  = sync_r.scl && !prev_r.scl;
  assign scl_fall  = !sync_r.scl && prev_r.scl;
  // [RULE1] sda edges under high clock are conditions
  // [RULE2] start needs falling sda, clock high
  assign start_evt = !busy && sync_r.scl && prev_r.scl && prev_r.sda && !sync_r.sda;
  assign stop_evt  = !busy && sync_r.scl && prev_r.scl && !prev_r.sda && sync_r.sda;

  // ***********************
  // state
  // ***********************
  port_state_e state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic        acked_r;
  logic        tgt_ccr_r;
  logic        rd_r;
  logic [15:0] addr_cnt_r;
  logic [7:0]  addr_hi_r;
  logic [15:0] wr_base_r;
  logic [63:0] valid_r;
  logic        have_data_r;
  logic        status_wr_r;
  logic [7:0]  status_val_r;
  logic        wel_r;
  logic        register_write_enable_latch_r;
  logic [31:0] busy_cnt_r;
  logic [6:0]  commit_idx_r;
  logic [5:0]  commit_d_r;
  logic        commit_v_r;
  logic        commit_ccr_r;

  logic        rx_state;
  logic        ack_slot;
  logic        ack_end;
  logic        ack_ok;
  logic        id_arr;
  logic        id_ccr;
  logic        wdat_take;
  logic        wr_end;
  logic        wr_prot;
  logic        commit_go;
  logic        status_go;
  logic [7:0]  arr_rdata;
  logic [7:0]  ccr_rdata;
  logic [7:0]  buf_rdata;
  logic [7:0]  rd_byte;
  logic [5:0]  buf_idx;
  logic [15:0] commit_addr;
  logic        arr_we;
  logic        ccr_we;

  assign rx_state  = (state_r == ST_DEV) || (state_r == ST_AHI) || (state_r == ST_ALO) || (state_r == ST_WDAT);
  assign ack_slot  = rx_state && scl_fall && (bit_cnt_r == BIT_ACK);
  assign ack_end   = (state_r != ST_IDLE) && scl_fall && (bit_cnt_r == BIT_DONE);
  // [RULE7] nibble picks the target
  // [RULE8] full seven-bit compare
  assign id_arr    = (shift_r[7:1] == ARRAY_ID);
  assign id_ccr    = (shift_r[7:1] == CCR_ID);
  assign rd_byte   = tgt_ccr_r ? ccr_rdata : arr_rdata;
  assign buf_idx   = tgt_ccr_r ? {3'h0, addr_cnt_r[SECT_AW-1:0]} : addr_cnt_r[PAGE_AW-1:0];

  // [RULE5] ack decision per byte kind
  always_comb begin
    case (state_r)
      ST_DEV:  ack_ok = id_arr || id_ccr;
      ST_AHI:  ack_ok = 1'b1;
      ST_ALO:  ack_ok = 1'b1;
      ST_WDAT: ack_ok = status_wr_r ? !have_data_r : wel_r;
      default: ack_ok = 1'b0;
    endcase
  end

  assign wdat_take = ack_slot && (state_r == ST_WDAT) && ack_ok;
  // [RULE16] stop only counts on a byte boundary after an ack
  // the stop's own clock rise is already counted as one bit
  assign wr_end    = stop_evt && (state_r == ST_WDAT) && (bit_cnt_r == 4'h1) && have_data_r;
  assign wr_prot   = prot.en && !tgt_ccr_r && (wr_base_r >= prot.base);
  // [RULE14] protected block: acked, no cycle
  assign commit_go = wr_end && !status_wr_r && (tgt_ccr_r ? register_write_enable_latch_r : !wr_prot);
  assign status_go = wr_end && status_wr_r;

  // ***********************
  // bit engine and byte sequencing
  // ***********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      sda_oe    <= 1'b0;
      acked_r   <= 1'b0;
      tgt_ccr_r <= 1'b0;
      rd_r      <= 1'b0;
    end else if (busy) begin
      // [RULE13] bus ignored and line released while busy
      state_r   <= ST_IDLE;
      sda_oe    <= 1'b0;
    end else if (start_evt) begin
      state_r   <= ST_DEV;
      bit_cnt_r <= 4'h0;
      sda_oe    <= 1'b0;
    end else if (stop_evt) begin
      // [RULE3] stop returns to standby
      // [RULE22] stop after address just leaves counter loaded
      state_r   <= ST_IDLE;
      sda_oe    <= 1'b0;
    end else if (rx_state) begin
      if (scl_rise && (bit_cnt_r < BIT_ACK)) begin
        shift_r   <= {shift_r[6:0], sync_r.sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (ack_slot) begin
        // [RULE4] receiver pulls low in ninth clock
        sda_oe    <= ack_ok;
        acked_r   <= ack_ok;
        bit_cnt_r <= BIT_DONE;
        if (state_r == ST_DEV) begin
          tgt_ccr_r <= id_ccr;
          rd_r      <= shift_r[0];
        end
      end else if (ack_end) begin
        sda_oe    <= 1'b0;
        bit_cnt_r <= 4'h0;
        // refused extra status byte keeps the first one pending for stop
        if (!acked_r && !((state_r == ST_WDAT) && status_wr_r)) begin
          state_r <= ST_IDLE;
        end else begin
          case (state_r)
            ST_DEV: begin
              if (rd_r) begin
                // [RULE9] read takes its address from the counter
                state_r <= ST_RDAT;
                tx_r    <= {rd_byte[6:0], 1'b0};
                sda_oe  <= !rd_byte[7];
              end else begin
                state_r <= ST_AHI;
              end
            end
            ST_AHI:  state_r <= ST_ALO;
            ST_ALO:  state_r <= ST_WDAT;
            default: state_r <= state_r;
          endcase
        end
      end
    end else if (state_r == ST_RDAT) begin
      // [RULE6] send eight, release, sample master ack
      if (scl_fall && (bit_cnt_r < BIT_LAST)) begin
        sda_oe    <= !tx_r[7];
        tx_r      <= {tx_r[6:0], 1'b0};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (scl_fall && (bit_cnt_r == BIT_LAST)) begin
        sda_oe    <= 1'b0;
        bit_cnt_r <= BIT_ACK;
      end else if (scl_rise && (bit_cnt_r == BIT_ACK)) begin
        if (sync_r.sda) begin
          state_r <= ST_IDLE;
        end else begin
          bit_cnt_r <= BIT_DONE;
        end
      end else if (ack_end) begin
        tx_r      <= {rd_byte[6:0], 1'b0};
        sda_oe    <= !rd_byte[7];
        bit_cnt_r <= 4'h0;
      end
    end
  end

  // ***********************
  // address counter
  // ***********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // [RULE10] counter starts at zero
      addr_cnt_r <= ADDR_RST;
      addr_hi_r  <= 8'h00;
    end else if (ack_slot && (state_r == ST_AHI)) begin
      addr_hi_r  <= shift_r;
    end else if (ack_slot && (state_r == ST_ALO)) begin
      addr_cnt_r <= {addr_hi_r, shift_r};
    end else if (wdat_take && !status_wr_r) begin
      // [RULE15] increment wraps within page or section
      if (tgt_ccr_r) begin
        addr_cnt_r[SECT_AW-1:0] <= addr_cnt_r[SECT_AW-1:0] + 3'h1;
      end else begin
        addr_cnt_r[PAGE_AW-1:0] <= addr_cnt_r[PAGE_AW-1:0] + 6'h01;
      end
    end else if ((state_r == ST_RDAT) && scl_fall && (bit_cnt_r == BIT_LAST) && !start_evt && !stop_evt) begin
      // [RULE19] one past the byte just sent
      // [RULE25] full 16-bit wrap
      addr_cnt_r <= addr_cnt_r + 16'h0001;
    end
  end

  // ***********************
  // write staging
  // ***********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_base_r    <= ADDR_RST;
      valid_r      <= '0;
      have_data_r  <= 1'b0;
      status_wr_r  <= 1'b0;
      status_val_r <= 8'h00;
    end else if (ack_slot && (state_r == ST_ALO)) begin
      wr_base_r    <= {addr_hi_r, shift_r};
      valid_r      <= '0;
      have_data_r  <= 1'b0;
      status_wr_r  <= tgt_ccr_r && ({addr_hi_r, shift_r} == STATUS_ADDR);
    end else if (wdat_take) begin
      if (status_wr_r) begin
        status_val_r <= shift_r;
      end else begin
        valid_r[buf_idx] <= 1'b1;
      end
    end else if (ack_end && (state_r == ST_WDAT) && acked_r) begin
      have_data_r  <= 1'b1;
    end else if (start_evt || stop_evt) begin
      have_data_r  <= 1'b0;
    end
  end

  // ***********************
  // enable latches
  // ***********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wel_r  <= 1'b0;
      register_write_enable_latch_r <= 1'b0;
    end else if (status_go) begin
      case (status_val_r)
        // [RULE24] zero clears both
        SR_CLEAR: begin
          wel_r  <= 1'b0;
          register_write_enable_latch_r <= 1'b0;
        end
        SR_SET_WEL: wel_r <= 1'b1;
        SR_SET_REGISTER_WRITE_ENABLE_LATCH: begin
          register_write_enable_latch_r <= wel_r;
          wel_r  <= 1'b1;
        end
        default: wel_r <= wel_r;
      endcase
    end else if (busy && commit_ccr_r && (busy_cnt_r == 32'h1)) begin
      // [RULE23] register cycle end drops latch
      register_write_enable_latch_r <= 1'b0;
    end
  end

  // ***********************
  // nonvolatile write cycle
  // ***********************
  // [RULE26] busy length from NVW_LEN
  // [RULE17] no ack while busy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy         <= 1'b0;
      busy_cnt_r   <= 32'h0;
      commit_idx_r <= 7'h00;
      commit_d_r   <= 6'h00;
      commit_v_r   <= 1'b0;
      commit_ccr_r <= 1'b0;
    end else if (commit_go) begin
      // [RULE13] valid stop launches cycle
      busy         <= 1'b1;
      busy_cnt_r   <= NVW_LEN[31:0];
      commit_idx_r <= 7'h00;
      commit_v_r   <= 1'b0;
      commit_ccr_r <= tgt_ccr_r;
    end else if (busy) begin
      busy_cnt_r   <= busy_cnt_r - 32'h1;
      busy         <= (busy_cnt_r > 32'h1);
      commit_d_r   <= commit_idx_r[5:0];
      commit_v_r   <= !commit_idx_r[6];
      if (!commit_idx_r[6]) begin
        commit_idx_r <= commit_idx_r + 7'h01;
      end
    end else begin
      commit_v_r   <= 1'b0;
    end
  end

  // copy walk needs 64 busy cycles; shorter busy lengths truncate it
  assign commit_addr = commit_ccr_r ? {wr_base_r[15:SECT_AW], commit_d_r[SECT_AW-1:0]}
                                    : {wr_base_r[15:PAGE_AW], commit_d_r};
  assign arr_we      = commit_v_r && !commit_ccr_r && valid_r[commit_d_r];
  assign ccr_we      = commit_v_r && commit_ccr_r && valid_r[commit_d_r];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ***********************
  // storage
  // ***********************
  byte_ram #(.DEPTH(64), .AW(PAGE_AW)) u_page_buf (
    .clk   (clk),
    .we    (wdat_take && !status_wr_r),
    .waddr (buf_idx),
    .wdata (shift_r),
    .raddr (commit_idx_r[5:0]),
    .rdata (buf_rdata)
  );

  byte_ram #(.DEPTH(ARRAY_DEPTH), .AW(ARRAY_AW)) u_array (
    .clk   (clk),
    .we    (arr_we),
    .waddr (commit_addr[ARRAY_AW-1:0]),
    .wdata (buf_rdata),
    .raddr (addr_cnt_r[ARRAY_AW-1:0]),
    .rdata (arr_rdata)
  );

  byte_ram #(.DEPTH(CCR_DEPTH), .AW(CCR_AW)) u_ccr (
    .clk   (clk),
    .we    (ccr_we),
    .waddr (commit_addr[CCR_AW-1:0]),
    .wdata (buf_rdata),
    .raddr (addr_cnt_r[CCR_AW-1:0]),
    .rdata (ccr_rdata)
  );

endmodule

// >>> tb/testbench.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
  import twi_slave_pkg::*;
  localparam int NVW = 400;
  logic       clk;
  logic       arst_n;
  prot_cfg_s  prot;
  twi_in_s    bus_in;
  logic       sda_o;
  logic       sda_oe;
  logic       busy;
  logic       nk;
  logic [7:0] rd;
  int         error_cnt = 0;
  int         n_compared = 0;
  int         cyc = 0;

  twi_slave_port #(.NVW_LEN(NVW)) twi_slave_port_i (
    .clk    (clk),
    .arst_n (arst_n),
    .bus_in (bus_in),
    .prot   (prot),
    .sda_o  (sda_o),
    .sda_oe (sda_oe),
    .busy   (busy)
  );
  twi_master twi_master_i (
    .clk    (clk),
    .sda_oe (sda_oe),
    .bus_in (bus_in)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // whole run needs some 24000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****
  // shared steps
  // ****
  task automatic tx(input logic [7:0] d, input logic e);
    twi_master_i.wbyte(d, nk);
    `CHK("ack", e, nk)
  endtask
  task automatic go(input logic [7:0] s, input logic [15:0] a);
    twi_master_i.start();
    tx(s, 1'b0);
    tx(a[15:8], 1'b0);
    tx(a[7:0], 1'b0);
  endtask
  task automatic rx(input logic m, input logic [7:0] e);
    twi_master_i.rbyte(m, rd);
    `CHK("data", e, rd)
  endtask
  task automatic idle();
    for (int i = 0; i < NVW + 50 && busy !== 1'b0; i++)
      @(negedge clk);
    `CHK("busy", 1'b0, busy)
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_bad_id();
    twi_master_i.start();
    tx(8'ha0, 1'b1);
    twi_master_i.start();
    tx(8'h5e, 1'b1);
    twi_master_i.stop();
  endtask
  task automatic t_wel_off();
    go(8'hae, 16'h0020);
    tx(8'h33, 1'b1);
    twi_master_i.stop();
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic t_status(input logic [7:0] v);
    go(8'hde, STATUS_ADDR);
    tx(v, 1'b0);
    tx(v, 1'b1);
    twi_master_i.stop();
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic t_page();
    go(8'hae, 16'h007e);
    for (int i = 0; i < 4; i++)
      tx(8'hc0 + i[7:0], 1'b0);
    twi_master_i.stop();
    `CHK("busy", 1'b1, busy)
    // polls use the array slave byte
    twi_master_i.start();
    tx(8'hae, 1'b1);
    idle();
    twi_master_i.start();
    tx(8'hae, 1'b0);
    tx(8'h00, 1'b0);
    tx(8'h40, 1'b0);
    twi_master_i.start();
    tx(8'haf, 1'b0);
    rx(1'b0, 8'hc2);
    rx(1'b1, 8'hc3);
    twi_master_i.stop();
  endtask
  task automatic t_set_addr();
    go(8'hae, 16'h007e);
    twi_master_i.stop();
    `CHK("busy", 1'b0, busy)
    twi_master_i.start();
    tx(8'haf, 1'b0);
    rx(1'b1, 8'hc0);
    twi_master_i.stop();
    twi_master_i.start();
    tx(8'haf, 1'b0);
    rx(1'b1, 8'hc1);
    twi_master_i.stop();
  endtask
  task automatic t_prot();
    prot = '{en: 1'b1, base: 16'h0100};
    go(8'hae, 16'h0180);
    tx(8'h77, 1'b0);
    twi_master_i.stop();
    `CHK("busy", 1'b0, busy)
    twi_master_i.start();
    tx(8'hae, 1'b0);
    twi_master_i.stop();
    prot = '{en: 1'b0, base: 16'h0000};
  endtask
  // a torn byte of zeros must leave the stored byte alone
  task automatic t_abort();
    go(8'hae, 16'h0000);
    tx(8'h5a, 1'b0);
    twi_master_i.stop();
    idle();
    go(8'hae, 16'h0000);
    for (int i = 0; i < 4; i++)
      twi_master_i.bit_io(1'b0, nk);
    twi_master_i.stop();
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic t_reset();
    arst_n = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    twi_master_i.start();
    tx(8'haf, 1'b0);
    rx(1'b1, 8'h5a);
    twi_master_i.stop();
  endtask

  // register bank: enable pair, section wrap, latch gone after the cycle
  task automatic t_ccr();
    t_status(SR_SET_WEL);
    t_status(SR_SET_REGISTER_WRITE_ENABLE_LATCH);
    go(8'hde, 16'h0016);
    for (int i = 0; i < 3; i++)
      tx(8'ha0 + i[7:0], 1'b0);
    twi_master_i.stop();
    `CHK("busy", 1'b1, busy)
    idle();
    go(8'hde, 16'h0010);
    tx(8'h55, 1'b0);
    twi_master_i.stop();
    `CHK("busy", 1'b0, busy)
    go(8'hde, 16'h0010);
    twi_master_i.start();
    tx(8'hdf, 1'b0);
    rx(1'b1, 8'ha2);
    twi_master_i.stop();
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    prot = '{en: 1'b0, base: 16'hffff};
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_bad_id();
    t_wel_off();
    t_status(SR_SET_WEL);
    t_page();
    t_set_addr();
    t_prot();
    t_abort();
    t_ccr();
    t_status(SR_CLEAR);
    t_wel_off();
    t_reset();
    end_of_test();
  end
endmodule

// >>> tb/twi_master.sv
// behavioural two-wire bus master facing the slave port
`timescale 1ns/1ns
module twi_master
  import twi_slave_pkg::*;
#(
  parameter int H = 10
) (
  input  wire logic              clk,
  input  wire logic              sda_oe,
  output twi_slave_pkg::twi_in_s bus_in
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;

  // pulled-up wire, low when either side pulls
  assign bus_in = '{scl: scl_m, sda: sda_m & ~sda_oe};

  task automatic hc();
    repeat (H) @(negedge clk);
  endtask

  // data moves only while clock low
  task automatic start();
    sda_m = 1'b1;
    hc();
    scl_m = 1'b1;
    hc();
    sda_m = 1'b0;
    hc();
    scl_m = 1'b0;
    hc();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    hc();
    scl_m = 1'b1;
    hc();
    sda_m = 1'b1;
    hc();
  endtask

  // sampled at the end of high, after the slave has settled
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    hc();
    scl_m = 1'b1;
    hc();
    r = bus_in.sda;
    scl_m = 1'b0;
    hc();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic nk);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, nk);
  endtask

  // high ninth slot ends a read
  task automatic rbyte(input logic nk, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nk, r);
  endtask
endmodule

// >>> tb/twi_slave_chk.sv
// pin-level assertions for the two-wire slave port
`timescale 1ns/1ns
module twi_slave_chk
  import twi_slave_pkg::*;
#(
  parameter int NVW_LEN = 100
) (
  input wire logic                     clk,
  input wire logic                     arst_n,
  input wire twi_slave_pkg::twi_in_s   bus_in,
  input wire twi_slave_pkg::prot_cfg_s prot,
  input wire logic                     sda_o,
  input wire logic                     sda_oe,
  input wire logic                     busy
);
  // ****
  // helper state
  // ****
  twi_in_s    prev_r;
  logic       seen_r;
  logic [3:0] sage_r;
  logic [3:0] fage_r;
  int         bcnt_r;
  logic       stop_ev;
  logic       start_ev;

  assign stop_ev  = prev_r.scl & bus_in.scl & ~prev_r.sda & bus_in.sda;
  assign start_ev = prev_r.scl & bus_in.scl & prev_r.sda & ~bus_in.sda;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      prev_r <= '1;
    else
      prev_r <= bus_in;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      seen_r <= 1'b0;
    else if (start_ev)
      seen_r <= 1'b1;
  end

  // saturating ages: cycles since last stop, since last clock fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      sage_r <= 4'hf;
    else if (stop_ev)
      sage_r <= 4'h0;
    else if (sage_r != 4'hf)
      sage_r <= sage_r + 4'h1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      fage_r <= 4'hf;
    else if (bus_in.scl)
      fage_r <= 4'hf;
    else if (prev_r.scl)
      fage_r <= 4'h0;
    else if (fage_r != 4'hf)
      fage_r <= fage_r + 4'h1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      bcnt_r <= 0;
    else if (busy)
      bcnt_r <= bcnt_r + 1;
    else
      bcnt_r <= 0;
  end

  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_stop;
    stop_ev;
  endsequence
  sequence s_rel6;
    !sda_oe [*6];
  endsequence
  sequence s_busy7;
    busy [*7];
  endsequence

  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data output not held low");
  a_busy_quiet: assert property (busy |-> !sda_oe)
    else $error("line driven while busy");
  a_oe_timing: assert property ($changed(sda_oe) |-> fage_r >= 4'h1 && fage_r <= 4'h6)
    else $error("drive changed away from a clock fall");
  a_busy_len: assert property ($fell(busy) |-> bcnt_r >= NVW_LEN && bcnt_r <= NVW_LEN + 1)
    else $error("busy interval has wrong length");
  a_busy_cause: assert property ($rose(busy) |-> sage_r <= 4'h8)
    else $error("busy began without a stop");
  a_idle_quiet: assert property (!seen_r |-> !sda_oe)
    else $error("line driven before any start");
  a_stop_release: assert property (s_stop |-> ##1 s_rel6)
    else $error("line driven right after stop");
  a_busy_hold: assert property ($rose(busy) |=> s_busy7)
    else $error("busy dropped early");
endmodule

bind twi_slave_port twi_slave_chk #(.NVW_LEN(NVW_LEN)) twi_slave_chk_i (
  .clk    (clk),
  .arst_n (arst_n),
  .bus_in (bus_in),
  .prot   (prot),
  .sda_o  (sda_o),
  .sda_oe (sda_oe),
  .busy   (busy)
);
